//--- core/dprn_pkg.sv
package dprn_pkg;
  // register byte addresses
  localparam logic [7:0] RANGE_CFG_ADDR = 8'h74;
  localparam logic [7:0] NOISE_WIN_ADDR = 8'h80;
  localparam logic [7:0] IRQ_STS_ADDR = 8'h84;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h88;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h8C;
  // reset values
  localparam logic [7:0] RANGE_CFG_RST = 8'h85;
  localparam logic [7:0] NOISE_WIN_RST = 8'h06;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  // field positions
  localparam int COARSE_LOSS_BIT = 7;
  localparam int WIDE_RANGE_BIT = 6;
  localparam int MULTI_CYCLE_BIT = 5;
  localparam int EDGE_WIN_BIT = 7;
  localparam int IRQ_LOSS_BIT = 0;
  localparam int IRQ_REJECT_BIT = 1;
  // range code saturates at this value
  localparam logic [3:0] RANGE_CODE_MAX = 4'hC;
  localparam logic [13:0] SPAN_ONE_UI = 14'h0001;
  // edge window: percent of the period around the expected edge
  localparam int EDGE_WIN_PCT = 5;
  localparam logic [4:0] EDGE_WIN_RATIO = 5'(100 / EDGE_WIN_PCT);

  typedef struct packed {
    logic coarse_loss_en;
    logic wide_range_en;
    logic multi_cycle_response_enable;
    logic unused4;
    logic [3:0] range_code;
  } dprn_range_cfg_t;

  typedef struct packed {
    logic edge_window_enable;
    logic [6:0] spare;
  } dprn_noise_cfg_t;
endpackage : dprn_pkg

//--- core/dprn_top.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1 - the range code picks a tracked span of +/-(2^(n+1)-1) UI, saturating at 8191 UI for codes 12 to 15.
// RULE2 - one range code sets both the coarse phase-loss span and the coarse phase detector span.
// RULE3 - the wide-range enable and the coarse-limit phase-loss enable both use the programmed code.
// RULE4 - the primary_dpll range register is read/write and resets to 0x85.
// RULE5 - with the edge window on, low-frequency input edges outside 5% of the expected time are dropped.
// RULE6 - with the edge window off every edge is used; the window register resets to 0x06.
// RULE7 - the wide-range enable turns the wide-range phase detector on or off.
// RULE8 - phase loss is flagged when the tracked error exceeds the span and the loss enable is set.
module dprn_top (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic PHASE_VALID_I,
  input wire logic signed [15:0] PHASE_ERR_I,
  input wire logic EDGE_I,
  input wire logic LOW_FREQ_I,
  input wire logic signed [15:0] EDGE_OFFSET_I,
  input wire logic [15:0] PERIOD_CYC_I,
  output logic [13:0] SPAN_UI_O,
  output logic signed [15:0] COARSE_PHASE_O,
  output logic signed [15:0] DPLL_PHASE_O,
  output logic WIDE_RANGE_O,
  output logic PHASE_LOSS_O,
  output logic EDGE_USE_O,
  output logic IRQ_O
);
  dprn_pkg::dprn_range_cfg_t range_q;
  dprn_pkg::dprn_noise_cfg_t noise_q;
  logic [1:0] irq_sts_q;
  logic [1:0] irq_en_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_now;
  logic [13:0] span;
  logic [15:0] err_mag;
  logic [15:0] off_mag;
  logic loss_now;
  logic in_window;
  logic edge_accept;
  logic edge_reject;
  logic loss_rise;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  function automatic logic signed [15:0] clamp_err(input logic signed [15:0] e,
                                                   input logic [15:0] mag,
                                                   input logic [13:0] lim);
    logic signed [15:0] l;
    l = $signed({2'h0, lim});
    if (mag > {2'h0, lim}) begin
      clamp_err = e[15] ? -l : l;
    end else begin
      clamp_err = e;
    end
  endfunction : clamp_err

  // bus: one wait cycle, answer on the second edge of a request
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_now = AVS_WRITE_I & ack_q;

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  // read data captured in the wait cycle so it stands at the answering edge
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rdata_q <= 32'h0;
    end else if (AVS_READ_I & ~ack_q) begin
      case (AVS_ADDRESS_I)
        dprn_pkg::RANGE_CFG_ADDR: rdata_q <= {24'h0, range_q}; // RULE4
        dprn_pkg::NOISE_WIN_ADDR: rdata_q <= {24'h0, noise_q};
        dprn_pkg::IRQ_STS_ADDR: rdata_q <= {30'h0, irq_sts_q};
        dprn_pkg::IRQ_EN_ADDR: rdata_q <= {30'h0, irq_en_q};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign AVS_READDATA_O = rdata_q;

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      range_q <= dprn_pkg::RANGE_CFG_RST; // RULE4
    end else if (wr_now && AVS_ADDRESS_I == dprn_pkg::RANGE_CFG_ADDR) begin
      range_q <= AVS_WRITEDATA_I[7:0]; // RULE4
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      noise_q <= dprn_pkg::NOISE_WIN_RST; // RULE6
    end else if (wr_now && AVS_ADDRESS_I == dprn_pkg::NOISE_WIN_ADDR) begin
      noise_q <= AVS_WRITEDATA_I[7:0];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      irq_en_q <= dprn_pkg::IRQ_EN_RST;
    end else if (wr_now && AVS_ADDRESS_I == dprn_pkg::IRQ_EN_ADDR) begin
      irq_en_q <= AVS_WRITEDATA_I[1:0];
    end
  end

  // span from the code, saturated at the top code
  always_comb begin
    if (range_q.range_code >= dprn_pkg::RANGE_CODE_MAX) begin
      span = 14'((15'h1 << (dprn_pkg::RANGE_CODE_MAX + 4'h1)) - 15'h1); // RULE1
    end else begin
      span = 14'((15'h1 << (range_q.range_code + 4'h1)) - 15'h1); // RULE1
    end
  end

  assign err_mag = PHASE_ERR_I[15] ? 16'(-PHASE_ERR_I) : PHASE_ERR_I;
  // same span feeds loss detection and the coarse measurement
  assign loss_now = PHASE_VALID_I & range_q.coarse_loss_en & (err_mag > {2'h0, span}); // RULE2 RULE3 RULE8

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      PHASE_LOSS_O <= 1'b0;
    end else if (!range_q.coarse_loss_en) begin
      PHASE_LOSS_O <= 1'b0; // RULE8
    end else if (PHASE_VALID_I) begin
      PHASE_LOSS_O <= loss_now; // RULE8
    end
  end
  assign loss_rise = loss_now & ~PHASE_LOSS_O;

  // without wide range the detector can only see one cycle of error
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      COARSE_PHASE_O <= 16'sh0;
      DPLL_PHASE_O <= 16'sh0;
      SPAN_UI_O <= dprn_pkg::SPAN_ONE_UI;
      WIDE_RANGE_O <= 1'b0;
    end else begin
      WIDE_RANGE_O <= range_q.wide_range_en; // RULE7
      SPAN_UI_O <= span; // RULE2
      if (PHASE_VALID_I) begin
        COARSE_PHASE_O <= clamp_err(PHASE_ERR_I, err_mag,
            range_q.wide_range_en ? span : dprn_pkg::SPAN_ONE_UI); // RULE3 RULE7
        DPLL_PHASE_O <= clamp_err(PHASE_ERR_I, err_mag,
            (range_q.wide_range_en & range_q.multi_cycle_response_enable)
            ? span : dprn_pkg::SPAN_ONE_UI);
      end
    end
  end

  // window test |offset| * 20 <= period, i.e. within 5% of the period
  assign off_mag = EDGE_OFFSET_I[15] ? 16'(-EDGE_OFFSET_I) : EDGE_OFFSET_I;
  assign in_window = (21'(off_mag) * 21'(dprn_pkg::EDGE_WIN_RATIO)) <= 21'(PERIOD_CYC_I); // RULE5
  assign edge_accept = EDGE_I & (~noise_q.edge_window_enable | ~LOW_FREQ_I | in_window); // RULE5 RULE6
  assign edge_reject = EDGE_I & ~edge_accept; // RULE5

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      EDGE_USE_O <= 1'b0;
    end else begin
      EDGE_USE_O <= edge_accept; // RULE5 RULE6
    end
  end

  // sticky events; a set in the clearing cycle survives
  always_comb begin
    irq_set = 2'h0;
    irq_set[dprn_pkg::IRQ_LOSS_BIT] = loss_rise;
    irq_set[dprn_pkg::IRQ_REJECT_BIT] = edge_reject;
    irq_clr = (wr_now && AVS_ADDRESS_I == dprn_pkg::IRQ_CLR_ADDR) ? AVS_WRITEDATA_I[1:0] : 2'h0;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      irq_sts_q <= 2'h0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
    end
  end
  assign IRQ_O = |(irq_sts_q & irq_en_q);

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_req_first;
    (AVS_READ_I | AVS_WRITE_I) && !ack_q;
  endsequence

  a_bus_wait_one: assert property (s_req_first |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("bus answer not on second edge");
  a_range_reset_val: assert property ($fell(RESET_I) |-> range_q == dprn_pkg::RANGE_CFG_RST) // RULE4
    else $error("range register reset value wrong");
  a_noise_reset_val: assert property ($fell(RESET_I) |-> noise_q == dprn_pkg::NOISE_WIN_RST) // RULE6
    else $error("window register reset value wrong");
  a_span_saturate: assert property (range_q.range_code >= 4'hC |=> SPAN_UI_O == 14'h1FFF) // RULE1
    else $error("span not saturated");
  a_span_code_five: assert property (range_q.range_code == 4'h5 |=> SPAN_UI_O == 14'h3F) // RULE1
    else $error("span for code five wrong");
  a_loss_exceeds: assert property (PHASE_VALID_I && range_q.coarse_loss_en
      && err_mag > {2'h0, span} |=> PHASE_LOSS_O) // RULE8
    else $error("phase loss missed");
  a_loss_disabled: assert property (!range_q.coarse_loss_en |=> !PHASE_LOSS_O) // RULE3
    else $error("phase loss while disabled");
  a_coarse_span: assert property (PHASE_VALID_I && range_q.wide_range_en |=>
      (COARSE_PHASE_O <= $signed({2'h0, $past(span)}))
      && (COARSE_PHASE_O >= -$signed({2'h0, $past(span)}))) // RULE2
    else $error("coarse phase outside span");
  a_edges_all_used: assert property (EDGE_I && !noise_q.edge_window_enable |=> EDGE_USE_O) // RULE6
    else $error("edge dropped with window off");
  a_edge_rejected: assert property (EDGE_I && noise_q.edge_window_enable && LOW_FREQ_I
      && !in_window |=> !EDGE_USE_O ##0 irq_sts_q[dprn_pkg::IRQ_REJECT_BIT]) // RULE5
    else $error("out of window edge used");
  a_wide_follows: assert property ($changed(range_q.wide_range_en) |=>
      WIDE_RANGE_O == $past(range_q.wide_range_en)) // RULE7
    else $error("wide range output stale");
endmodule : dprn_top

//--- sim/dprn_top_tb.sv
`timescale 1ns/1ns
module dprn_top_tb;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, pv = 1'b0, edg = 1'b0, lf = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic signed [15:0] perr = 16'sh0, eoff = 16'sh0;
  logic [15:0] per = 16'h0064;
  logic [13:0] span;
  logic signed [15:0] coarse, dphase;
  logic wait_o, wide, loss, use_o, irq;
  int fails = 0, check_count = 0;
  always #20 clk = ~clk;
  dprn_top DUT (.REF_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .PHASE_VALID_I(pv), .PHASE_ERR_I(perr), .EDGE_I(edg),
    .LOW_FREQ_I(lf), .EDGE_OFFSET_I(eoff), .PERIOD_CYC_I(per), .SPAN_UI_O(span),
    .COARSE_PHASE_O(coarse), .DPLL_PHASE_O(dphase), .WIDE_RANGE_O(wide),
    .PHASE_LOSS_O(loss), .EDGE_USE_O(use_o), .IRQ_O(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_o !== 1'b0) @(posedge clk);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic phase(input logic signed [15:0] e);
    @(posedge clk); pv <= 1'b1; perr <= e;
    @(posedge clk); pv <= 1'b0;
    @(negedge clk);
  endtask : phase
  task automatic edge_in(input logic signed [15:0] o, input logic exp_use);
    @(posedge clk); edg <= 1'b1; eoff <= o;
    @(posedge clk); edg <= 1'b0;
    @(negedge clk); chk(32'(use_o), 32'(exp_use));
  endtask : edge_in
  // span shows its reset value until the first edge after release
  task automatic t_reset;
    @(negedge clk); chk(32'(span), 32'h1);
    @(negedge clk); chk(32'(span), 32'h3F);
    bus(0, 8'h74, 0); chk(r, 32'h85);
    bus(0, 8'h80, 0); chk(r, 32'h06);
    bus(0, 8'h90, 0); chk(r, 32'h0);
    bus(1, 8'h80, 32'h7F); bus(0, 8'h80, 0); chk(r, 32'h7F);
  endtask : t_reset
  task automatic t_range;
    logic [13:0] s;
    for (int c = 0; c < 16; c++) begin
      s = (c >= 12) ? 14'h1FFF : 14'((1 << (c + 1)) - 1);
      bus(1, 8'h74, 32'h40 | c);
      phase(16'sh2328);
      chk(32'(span), 32'(s));
      chk(32'(coarse), 32'(s));
      chk(32'(dphase), 32'h1);
      chk(32'(wide), 32'h1);
    end
    // multi-cycle response with wide range: both clamp to -63
    bus(1, 8'h74, 32'h65); phase(-16'sh2328);
    chk(32'(coarse), 32'hFFFFFFC1);
    chk(32'(dphase), 32'hFFFFFFC1);
    bus(1, 8'h74, 32'h25); phase(16'sh2328);
    chk(32'(dphase), 32'h1);
    bus(1, 8'h74, 32'h03); phase(16'sh2328);
    chk(32'(wide), 32'h0);
    chk(32'(coarse), 32'h1);
  endtask : t_range
  task automatic t_loss;
    bus(1, 8'h74, 32'h01); phase(16'sh4);
    chk(32'(loss), 32'h0);
    bus(1, 8'h74, 32'hC1); phase(16'sh3);
    chk(32'(loss), 32'h0);
    phase(-16'sh4);
    chk(32'(loss), 32'h1);
    bus(0, 8'h84, 0); chk(r, 32'h1);
    chk(32'(irq), 32'h0);
    bus(1, 8'h8C, 32'h1); @(negedge clk); chk(32'(irq), 32'h1);
    bus(0, 8'h8C, 0); chk(r, 32'h1);
    bus(1, 8'h88, 32'h1); @(negedge clk); chk(32'(irq), 32'h0);
    bus(0, 8'h84, 0); chk(r, 32'h0);
  endtask : t_loss
  task automatic t_window;
    lf <= 1'b1;
    edge_in(16'sh32, 1'b1);
    bus(1, 8'h80, 32'h80);
    edge_in(16'sh5, 1'b1);
    edge_in(-16'sh6, 1'b0);
    bus(0, 8'h84, 0); chk(r, 32'h2);
    bus(1, 8'h8C, 32'h2); @(negedge clk); chk(32'(irq), 32'h1);
    bus(1, 8'h88, 32'h2); @(negedge clk); chk(32'(irq), 32'h0);
    lf <= 1'b0;
    edge_in(16'sh32, 1'b1);
  endtask : t_window
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_range;
    t_loss;
    t_window;
    give_verdict;
  end
  initial begin
    #400000;
    fails++;
    give_verdict;
  end
endmodule : dprn_top_tb
